// >>> hw/ccl_comparator_ctrl.sv
`timescale 1ns/100ps
module ccl_comparator_ctrl
  import ccl_pkg::*;
#(
  parameter int LEVEL_W = 10  // Width of the digitised input levels.
) (
  input  wire logic                  i_core_clk,
  input  wire logic                  i_reset,
  input  wire logic [7:0]            i_reg_addr,
  input  wire logic                  i_reg_wr,
  input  wire logic                  i_reg_rd,
  input  wire logic [7:0]            i_reg_wdata,
  output logic      [7:0]            o_reg_rdata,
  input  wire logic [LEVEL_W-1:0]    i_positive_input_pin,
  input  wire logic [LEVEL_W-1:0]    i_negative_input_pin,
  input  wire logic [LEVEL_W-1:0]    i_bandgap_level,
  input  wire logic [8*LEVEL_W-1:0]  i_channel_levels,
  input  wire logic [2:0]            i_channel_select,
  input  wire logic                  i_converter_enable,
  input  wire logic                  i_auto_trigger_enable,
  input  wire ccl_trig_flags_t       i_trig_flags,
  input  wire logic                  i_global_irq_enable,
  input  wire logic                  i_irq_vector_taken,
  input  wire logic                  i_positive_pin_digital,
  input  wire logic                  i_negative_pin_digital,
  output logic                       o_compare_result,
  output logic                       o_comparator_irq,
  output logic                       o_capture_input,
  output logic                       o_conversion_start,
  output logic                       o_comparator_power_down,
  output logic                       o_positive_pin_read,
  output logic                       o_negative_pin_read
);

  // ****************************************************************
  // Register storage.
  // ****************************************************************
  logic [7:0]      ctrl_ff;        // Control bits of the status register, result and flag excluded.
  logic            flag_ff;        // Sticky comparator event flag.
  logic [7:0]      ctrl_b_ff;      // Converter control B.
  logic [7:0]      pin_dis_ff;     // Pin input disable bits.
  logic            raw_cmp;        // Raw analog comparison, modelled on levels.
  logic            sync1_ff;       // First synchroniser stage.
  logic            result_prev_ff; // Result one cycle back, for edge detection.
  logic            trig_prev_ff;   // Selected trigger flag one cycle back.
  logic            rise;           // One-cycle rising edge of the result.
  logic            fall;           // One-cycle falling edge of the result.
  logic            event_hit;      // Edge that matches the chosen mode.
  logic            trig_sel;       // Currently selected trigger flag.
  logic            wr_status;      // Write strobe to the status register.
  ccl_event_mode_t mode;           // Decoded event mode.
  ccl_trig_src_t   src;            // Decoded trigger source.

  assign wr_status = i_reg_wr && (i_reg_addr == CCL_COMPARATOR_CONTROL_STATUS_OFS);
  assign mode      = ccl_event_mode_t'(ctrl_ff[CCL_EVENT_MODE_LSB +: 2]);
  assign src       = ccl_trig_src_t'(ctrl_b_ff[CCL_TRIGGER_SOURCE_LSB +: 3]);

  // Picks one digitised converter channel level out of the packed bus.
  function automatic logic [LEVEL_W-1:0] pick_channel(input logic [8*LEVEL_W-1:0] lv,
                                                     input logic [2:0] sel);
    pick_channel = lv[sel*LEVEL_W +: LEVEL_W];
  endfunction

  // ****************************************************************
  // Analog input selection and comparison.
  // ****************************************************************
  // The comparator itself is analog; here the two chosen levels are compared
  // so the selection logic can be checked. A powered-down comparator reads low.
  always_comb begin
    logic [LEVEL_W-1:0] pos_lv;
    logic [LEVEL_W-1:0] neg_lv;
    pos_lv = i_positive_input_pin;
    neg_lv = i_negative_input_pin;
    if (ctrl_ff[CCL_BANDGAP_SELECT_BIT]) begin
      pos_lv = i_bandgap_level;
    end
    if (ctrl_b_ff[CCL_CHANNEL_ROUTE_ENABLE_BIT] && !i_converter_enable) begin
      neg_lv = pick_channel(i_channel_levels, i_channel_select);
    end
    raw_cmp = !ctrl_ff[CCL_COMPARATOR_DISABLE_BIT] && (pos_lv > neg_lv);
  end

  // ****************************************************************
  // Result synchroniser and edge detection.
  // ****************************************************************
  // Two flops: the first stage is read only by the second.
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      sync1_ff         <= 1'b0;
      o_compare_result <= 1'b0;
      result_prev_ff   <= 1'b0;
    end else begin
      sync1_ff         <= raw_cmp;
      o_compare_result <= sync1_ff;
      result_prev_ff   <= o_compare_result;
    end
  end

  assign rise = o_compare_result && !result_prev_ff;
  assign fall = !o_compare_result && result_prev_ff;

  // Mode decoding; the reserved code never raises an event.
  always_comb begin
    case (mode)
      CCL_MODE_TOGGLE: event_hit = rise || fall;
      CCL_MODE_FALL:   event_hit = fall;
      CCL_MODE_RISE:   event_hit = rise;
      default:         event_hit = 1'b0;
    endcase
  end

  // ****************************************************************
  // Control registers.
  // ****************************************************************
  // Status register control bits. Changing the disable or mode bits with the
  // interrupt enabled may flag a spurious event; software must avoid that.
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      ctrl_ff <= CCL_CONTROL_STATUS_RESET;
    end else if (wr_status) begin
      ctrl_ff <= i_reg_wdata & 8'hcf;  // Result and flag bits are not stored here.
    end
  end

  // Converter control B and pin input disable registers.
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      ctrl_b_ff  <= CCL_CONTROL_B_RESET;
      pin_dis_ff <= CCL_PIN_DISABLE_RESET;
    end else if (i_reg_wr) begin
      if (i_reg_addr == CCL_CONVERTER_CONTROL_B_OFS) begin
        ctrl_b_ff <= i_reg_wdata & 8'h47;
      end
      if (i_reg_addr == CCL_COMPARATOR_PIN_INPUT_DISABLE_OFS) begin
        pin_dis_ff <= i_reg_wdata;
      end
    end
  end

  // Event flag: a new event wins over a same-cycle clear.
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      flag_ff <= 1'b0;
    end else if (event_hit) begin
      flag_ff <= 1'b1;
    end else if (i_irq_vector_taken || (wr_status && i_reg_wdata[CCL_EVENT_FLAG_BIT])) begin
      flag_ff <= 1'b0;
    end
  end

  // Register read port, one cycle after the read strobe; unmapped reads give zero.
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_rd) begin
      case (i_reg_addr)
        CCL_COMPARATOR_CONTROL_STATUS_OFS: begin
          o_reg_rdata <= ctrl_ff | ({7'h00, o_compare_result} << CCL_COMPARE_RESULT_BIT)
                                 | ({7'h00, flag_ff} << CCL_EVENT_FLAG_BIT);
        end
        CCL_CONVERTER_CONTROL_B_OFS:          o_reg_rdata <= ctrl_b_ff;
        CCL_COMPARATOR_PIN_INPUT_DISABLE_OFS: o_reg_rdata <= pin_dis_ff;
        default:                              o_reg_rdata <= 8'h00;
      endcase
    end else begin
      o_reg_rdata <= 8'h00;
    end
  end

  // ****************************************************************
  // Converter auto-trigger selection.
  // ****************************************************************
  // Free-running selects a constant low, so switching to it cannot make an edge.
  always_comb begin
    case (src)
      CCL_TRIG_FREE_RUN: trig_sel = 1'b0;
      CCL_TRIG_COMPARE:  trig_sel = flag_ff;
      CCL_TRIG_EXT_INT0: trig_sel = i_trig_flags.ext_int0;
      CCL_TRIG_T0_CMPA:  trig_sel = i_trig_flags.t0_cmpa;
      CCL_TRIG_T0_OVF:   trig_sel = i_trig_flags.t0_ovf;
      CCL_TRIG_T1_CMPB:  trig_sel = i_trig_flags.t1_cmpb;
      CCL_TRIG_T1_OVF:   trig_sel = i_trig_flags.t1_ovf;
      CCL_TRIG_T1_CAPT:  trig_sel = i_trig_flags.t1_capt;
      default:           trig_sel = 1'b0;
    endcase
  end

  // A rising edge on the selected flag, including one made by switching
  // source, starts a conversion when auto-trigger and converter are on.
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      trig_prev_ff       <= 1'b0;
      o_conversion_start <= 1'b0;
    end else begin
      trig_prev_ff       <= trig_sel;
      o_conversion_start <= i_auto_trigger_enable && i_converter_enable
                            && trig_sel && !trig_prev_ff;
    end
  end

  // ****************************************************************
  // Interrupt, capture routing, power and pin outputs.
  // ****************************************************************
  // All outputs are registered, adding one cycle to each path.
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      o_comparator_irq        <= 1'b0;
      o_capture_input         <= 1'b0;
      o_comparator_power_down <= 1'b0;
      o_positive_pin_read     <= 1'b0;
      o_negative_pin_read     <= 1'b0;
    end else begin
      o_comparator_irq        <= flag_ff && ctrl_ff[CCL_IRQ_ENABLE_BIT] && i_global_irq_enable;
      o_capture_input         <= ctrl_ff[CCL_CAPTURE_ROUTE_BIT] && o_compare_result;
      o_comparator_power_down <= ctrl_ff[CCL_COMPARATOR_DISABLE_BIT];
      o_positive_pin_read     <= i_positive_pin_digital && !pin_dis_ff[CCL_POS_PIN_DISABLE_BIT];
      o_negative_pin_read     <= i_negative_pin_digital && !pin_dis_ff[CCL_NEG_PIN_DISABLE_BIT];
    end
  end

  // ****************************************************************
  // Assertions.
  // ****************************************************************
  // A rising result edge while rising mode is chosen.
  sequence seq_rise_in_rise_mode;
    rise && (mode == CCL_MODE_RISE);
  endsequence

  // A falling result edge while falling mode is chosen.
  sequence seq_fall_in_fall_mode;
    fall && (mode == CCL_MODE_FALL);
  endsequence

  AST_SYNC_LATENCY: assert property (@(posedge i_core_clk) disable iff (i_reset)
    ##2 (o_compare_result == $past(raw_cmp, 2)))
    else $error("Result does not follow comparison after two cycles.");

  AST_FLAG_RISE: assert property (@(posedge i_core_clk) disable iff (i_reset)
    seq_rise_in_rise_mode |=> flag_ff)
    else $error("Rising edge in rising mode did not set the flag.");

  AST_FLAG_FALL: assert property (@(posedge i_core_clk) disable iff (i_reset)
    seq_fall_in_fall_mode |=> flag_ff)
    else $error("Falling edge in falling mode did not set the flag.");

  AST_FLAG_CLEAR: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (!event_hit && i_irq_vector_taken) |=> !flag_ff)
    else $error("Vector taken did not clear the event flag.");

  AST_FLAG_HOLD: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (!flag_ff && !event_hit) |=> !flag_ff)
    else $error("Event flag set without a matching event.");

  AST_IRQ_GATE: assert property (@(posedge i_core_clk) disable iff (i_reset)
    ##1 (o_comparator_irq == $past(flag_ff && ctrl_ff[CCL_IRQ_ENABLE_BIT] && i_global_irq_enable)))
    else $error("Interrupt request does not match flag and enables.");

  AST_CAPTURE_OFF: assert property (@(posedge i_core_clk) disable iff (i_reset)
    !ctrl_ff[CCL_CAPTURE_ROUTE_BIT] |=> !o_capture_input)
    else $error("Capture input driven while routing is off.");

  AST_NO_FREE_RUN_TRIGGER: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (src == CCL_TRIG_FREE_RUN) |=> !o_conversion_start)
    else $error("Free-running source produced a trigger event.");

  AST_START_ON_EDGE: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (i_auto_trigger_enable && i_converter_enable && !trig_prev_ff && trig_sel) |=> o_conversion_start)
    else $error("Rising trigger flag did not start a conversion.");

  AST_PIN_DISABLE: assert property (@(posedge i_core_clk) disable iff (i_reset)
    pin_dis_ff[CCL_POS_PIN_DISABLE_BIT] |=> !o_positive_pin_read)
    else $error("Disabled positive pin reads non-zero.");

  AST_NEG_PIN_USED: assert property (@(posedge i_core_clk) disable iff (i_reset)
    ((!ctrl_b_ff[CCL_CHANNEL_ROUTE_ENABLE_BIT] || i_converter_enable) && !ctrl_ff[CCL_COMPARATOR_DISABLE_BIT]
     && !ctrl_ff[CCL_BANDGAP_SELECT_BIT]) |-> (raw_cmp == (i_positive_input_pin > i_negative_input_pin)))
    else $error("Negative pin not used when channel routing is off or the converter is on.");

  AST_POWER_DOWN: assert property (@(posedge i_core_clk) disable iff (i_reset)
    ctrl_ff[CCL_COMPARATOR_DISABLE_BIT] |=> o_comparator_power_down)
    else $error("Disable bit did not power the comparator down.");

endmodule

// >>> hw/ccl_pkg.sv
package ccl_pkg;

  // ****************************************************************
  // Register offsets in data space.
  // ****************************************************************
  localparam logic [7:0] CCL_COMPARATOR_CONTROL_STATUS_OFS    = 8'h50;
  localparam logic [7:0] CCL_CONVERTER_CONTROL_B_OFS          = 8'h7b;
  localparam logic [7:0] CCL_COMPARATOR_PIN_INPUT_DISABLE_OFS = 8'h7f;

  // ****************************************************************
  // Field positions.
  // ****************************************************************
  // Comparator control and status.
  localparam int CCL_COMPARATOR_DISABLE_BIT      = 7;
  localparam int CCL_BANDGAP_SELECT_BIT          = 6;
  localparam int CCL_COMPARE_RESULT_BIT          = 5;
  localparam int CCL_EVENT_FLAG_BIT              = 4;
  localparam int CCL_IRQ_ENABLE_BIT              = 3;
  localparam int CCL_CAPTURE_ROUTE_BIT           = 2;
  localparam int CCL_EVENT_MODE_LSB              = 0;
  // Converter control B.
  localparam int CCL_CHANNEL_ROUTE_ENABLE_BIT    = 6;
  localparam int CCL_TRIGGER_SOURCE_LSB          = 0;
  // Pin input disable.
  localparam int CCL_NEG_PIN_DISABLE_BIT         = 1;
  localparam int CCL_POS_PIN_DISABLE_BIT         = 0;

  // ****************************************************************
  // Reset values.
  // ****************************************************************
  localparam logic [7:0] CCL_CONTROL_STATUS_RESET = 8'h00;
  localparam logic [7:0] CCL_CONTROL_B_RESET      = 8'h00;
  localparam logic [7:0] CCL_PIN_DISABLE_RESET    = 8'h00;

  // Event mode encodings; the remaining code is reserved and sets nothing.
  typedef enum logic [1:0] {
    CCL_MODE_TOGGLE   = 2'h0,
    CCL_MODE_RESERVED = 2'h1,
    CCL_MODE_FALL     = 2'h2,
    CCL_MODE_RISE     = 2'h3
  } ccl_event_mode_t;

  // Auto-trigger source encodings.
  typedef enum logic [2:0] {
    CCL_TRIG_FREE_RUN  = 3'h0,
    CCL_TRIG_COMPARE   = 3'h1,
    CCL_TRIG_EXT_INT0  = 3'h2,
    CCL_TRIG_T0_CMPA   = 3'h3,
    CCL_TRIG_T0_OVF    = 3'h4,
    CCL_TRIG_T1_CMPB   = 3'h5,
    CCL_TRIG_T1_OVF    = 3'h6,
    CCL_TRIG_T1_CAPT   = 3'h7
  } ccl_trig_src_t;

  // Interrupt flags of the other peripherals that may trigger the converter.
  typedef struct packed {
    logic t1_capt;
    logic t1_ovf;
    logic t1_cmpb;
    logic t0_ovf;
    logic t0_cmpa;
    logic ext_int0;
  } ccl_trig_flags_t;

endpackage

// >>> testbench/ccl_far_side_model.sv
`timescale 1ns/100ps
// ****************************************************************
// Far side: peripheral flags that may trigger the converter, and a
// converter that counts the start pulses it receives.
// ****************************************************************
module ccl_far_side_model
  import ccl_pkg::*;
(
  input  wire logic            i_core_clk,
  input  wire logic            i_reset,
  input  wire ccl_trig_flags_t i_flag_req,
  input  wire logic            i_conversion_start,
  output ccl_trig_flags_t      o_trig_flags,
  output logic [7:0]           o_start_count
);
  // Flags change on the clock, as the peripherals that own them set them.
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      o_trig_flags <= '0;
    end else begin
      o_trig_flags <= i_flag_req;
    end
  end

  // Busy time is not modelled, so every start pulse counts; a double pulse shows up.
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      o_start_count <= 8'h00;
    end else if (i_conversion_start) begin
      o_start_count <= o_start_count + 8'h01;
    end
  end
endmodule

// >>> testbench/comparator_control_logic_tb.sv
`timescale 1ns/100ps
// ****************************************************************
// Bench: register tasks, comparison helper and the test sequence.
// ****************************************************************
module comparator_control_logic_tb
  import ccl_pkg::*;
;
  logic            clk = 1'b0;           // 25 MHz core clock.
  logic            rst = 1'b1;           // Active-high reset.
  logic [7:0]      addr = 8'h00, wdata = 8'h00, rdata;
  logic            wr = 1'b0, rd = 1'b0;
  logic [9:0]      pos = '0, neg = 10'h064, bg = '0;
  logic [79:0]     chl;                  // Channel n sits at level n*100.
  logic [2:0]      sel = 3'h0;
  logic            cen = 1'b0, aen = 1'b0, gie = 1'b0, vtak = 1'b0, pdig = 1'b0, ndig = 1'b0;
  ccl_trig_flags_t flag_req = '0, flags;
  logic            res, irq, cap, start, pd, pread, nread;
  logic [7:0]      cnt, c0;
  int              miscompares = 0, total_checks = 0, cycles = 0;
  logic [7:0]      addrs [4] = '{8'h50, 8'h7b, 8'h7f, 8'h51};

  always #20 clk = ~clk;
  initial for (int n = 0; n < 8; n++) chl[n*10 +: 10] = 10'(n * 100);

  ccl_comparator_ctrl #(.LEVEL_W(10)) DUT (
    .i_core_clk(clk), .i_reset(rst), .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_rd(rd),
    .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_positive_input_pin(pos), .i_negative_input_pin(neg),
    .i_bandgap_level(bg), .i_channel_levels(chl), .i_channel_select(sel), .i_converter_enable(cen),
    .i_auto_trigger_enable(aen), .i_trig_flags(flags), .i_global_irq_enable(gie),
    .i_irq_vector_taken(vtak), .i_positive_pin_digital(pdig), .i_negative_pin_digital(ndig),
    .o_compare_result(res), .o_comparator_irq(irq), .o_capture_input(cap), .o_conversion_start(start),
    .o_comparator_power_down(pd), .o_positive_pin_read(pread), .o_negative_pin_read(nread));

  ccl_far_side_model FAR (.i_core_clk(clk), .i_reset(rst), .i_flag_req(flag_req),
    .i_conversion_start(start), .o_trig_flags(flags), .o_start_count(cnt));

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Compares with case equality so an unknown never passes.
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One-cycle write strobe; the release edge keeps two writes apart.
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the read edge, so it is taken then.
  // The task ends on an edge, so whatever the caller drives next lands on one.
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] d;
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
    chk(nm, d & m, e);
    @(posedge clk);
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // A hang is cut short well past the few hundred cycles the sequence needs.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      wrap_up();
    end
  end

  initial begin
    tick(5);
    rst <= 1'b0;
    tick(2);
    chk("outs", {1'b0, res, irq, cap, start, pd, pread, nread}, 8'h00);
    foreach (addrs[i]) rd_chk("reset", addrs[i], 8'hff, 8'h00);
    wr_reg(8'h7b, 8'hff);
    rd_chk("ctlb", 8'h7b, 8'hff, 8'h47);
    wr_reg(8'h7b, 8'h00);
    // Event modes, interrupt enable held low while the mode changes.
    for (int m = 0; m < 4; m++) begin
      wr_reg(8'h50, 8'h10 | 8'(m));
      pos <= 10'h1f4;
      tick(6);
      rd_chk("rise", 8'h50, 8'hff, 8'h20 | ((m == 0 || m == 3) ? 8'h10 : 8'h00) | 8'(m));
      wr_reg(8'h50, 8'h10 | 8'(m));
      pos <= 10'h000;
      tick(6);
      rd_chk("fall", 8'h50, 8'hff, ((m == 0 || m == 2) ? 8'h10 : 8'h00) | 8'(m));
    end
    wr_reg(8'h50, 8'h20);
    rd_chk("ro", 8'h50, 8'hff, 8'h00);
    // Flag, enable and global enable gate the request; the vector clears it.
    wr_reg(8'h50, 8'h13);
    gie <= 1'b1;
    pos <= 10'h1f4;
    tick(6);
    wr_reg(8'h50, 8'h0b);
    tick(3);
    chk("irq", {7'h00, irq}, 8'h01);
    gie <= 1'b0;
    tick(3);
    chk("irq", {7'h00, irq}, 8'h00);
    gie <= 1'b1;
    tick(3);
    vtak <= 1'b1;
    tick(1);
    vtak <= 1'b0;
    tick(3);
    chk("irq", {7'h00, irq}, 8'h00);
    rd_chk("vec", 8'h50, 8'hff, 8'h2b);
    wr_reg(8'h50, 8'h03);
    wr_reg(8'h50, 8'h04);
    tick(4);
    chk("cap", {7'h00, cap}, 8'h01);
    wr_reg(8'h50, 8'h80);
    tick(5);
    chk("pd", {6'h00, pd, cap}, 8'h02);
    rd_chk("off", 8'h50, 8'he0, 8'h80);
    pos <= 10'h000;
    bg <= 10'h258;
    wr_reg(8'h50, 8'h40);
    tick(5);
    rd_chk("bg", 8'h50, 8'he0, 8'h60);
    wr_reg(8'h50, 8'h00);
    tick(5);
    rd_chk("bg", 8'h50, 8'he0, 8'h00);
    // Channel route; converter power reduction is held at zero by software.
    wr_reg(8'h7b, 8'h40);
    pos <= 10'h15e;
    for (int n = 0; n < 8; n++) begin
      sel <= 3'(n);
      tick(5);
      chk("mux", {7'h00, res}, (n < 4) ? 8'h01 : 8'h00);
    end
    cen <= 1'b1;
    tick(5);
    chk("mux", {7'h00, res}, 8'h01);
    cen <= 1'b0;
    wr_reg(8'h7b, 8'h00);
    tick(5);
    chk("mux", {7'h00, res}, 8'h01);
    pdig <= 1'b1;
    ndig <= 1'b1;
    for (int v = 0; v < 4; v++) begin
      wr_reg(8'h7f, 8'(v));
      tick(3);
      chk("pins", {6'h00, nread, pread}, {6'h00, ~2'(v)});
      rd_chk("pindis", 8'h7f, 8'hff, 8'(v));
    end
    // Converter trigger sources, one rising flag each.
    aen <= 1'b1;
    cen <= 1'b1;
    for (int s = 2; s < 8; s++) begin
      wr_reg(8'h7b, 8'(s));
      tick(2);
      c0 = cnt;
      flag_req <= ccl_trig_flags_t'(6'h01 << (s - 2));
      tick(4);
      chk("trig", cnt, c0 + 8'h01);
      flag_req <= '0;
      tick(2);
    end
    flag_req <= ccl_trig_flags_t'(6'h10);
    wr_reg(8'h7b, 8'h02);
    tick(3);
    c0 = cnt;
    wr_reg(8'h7b, 8'h06);
    tick(3);
    chk("switch", cnt, c0 + 8'h01);
    flag_req <= ccl_trig_flags_t'(6'h3f);
    tick(3);
    c0 = cnt;
    wr_reg(8'h7b, 8'h00);
    tick(4);
    chk("free", cnt, c0);
    flag_req <= '0;
    pos <= 10'h000;
    wr_reg(8'h50, 8'h13);
    wr_reg(8'h7b, 8'h01);
    tick(3);
    c0 = cnt;
    pos <= 10'h1f4;
    tick(8);
    chk("cmp", cnt, c0 + 8'h01);
    aen <= 1'b0;
    wr_reg(8'h7b, 8'h02);
    tick(3);
    c0 = cnt;
    flag_req <= ccl_trig_flags_t'(6'h01);
    tick(4);
    chk("noauto", cnt, c0);
    wrap_up();
  end
endmodule
